// >>> design/arb_pkg.sv
/*
 * Shared constants for the multi-master bus arbiter pair: processor status
 * codes, bus clock timing and the arbitration state encodings.
 * Assumes a single 40 MHz system clock from which the bus clock is derived.
 */
package arb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock rates and the bus clock divider.
    localparam int unsigned SYS_CLK_HZ    = 40_000_000;
    localparam int unsigned BUS_CLK_HZ    = 10_000_000;
    localparam int unsigned BUS_CLK_DIV   = SYS_CLK_HZ / BUS_CLK_HZ;
    localparam int unsigned DIV_W         = $clog2(BUS_CLK_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BUS_CLK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_RST  = DIV_W'(0);

    // Longest advised daisy chain at the bus clock rate above.
    localparam int unsigned MAX_CHAIN_LEN = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Processor status codes on the three status lines.
    localparam logic [2:0] STATUS_IDLE = 3'h7;
    localparam logic [2:0] STATUS_HALT = 3'h3;
    localparam logic [2:0] STATUS_RST  = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration states, one-hot.
    typedef enum logic [2:0] {
        ARB_RELEASED = 3'h1,
        ARB_WAITING  = 3'h2,
        ARB_OWNER    = 3'h4
    } arb_state_type;

endpackage : arb_pkg

// >>> design/arb_link_if.sv
/*
 * Link between one arbiter and the rest of the shared bus: the wired busy
 * and common request lines, the request and the priority lines.
 * Assumes both ends run on clk_sys; open-drain lines are resolved here.
 */
`timescale 1ns/1ps
interface arb_link_if;

    logic bclk_fall;        // One-cycle pulse at each falling bus clock edge.
    logic busy_oe_dev;      // Device end pulls busy low.
    logic busy_oe_far;      // Far end pulls busy low.
    logic common_request_line_oe_dev;      // Device end pulls the common request low.
    logic common_request_line_oe_far;      // Far end pulls the common request low.
    logic busy_n;           // Resolved wired busy level, active low.
    logic common_request_n; // Resolved wired common request level, active low.
    logic own_bus_request;  // Device end wants the bus.
    logic priority_in;      // Priority granted to the device end.
    logic priority_out;     // Priority passed on by the device end.

    // The open-drain lines float high unless some end pulls them low.
    assign busy_n           = ~(busy_oe_dev | busy_oe_far);
    assign common_request_n = ~(common_request_line_oe_dev | common_request_line_oe_far);

    modport device_end (
        input  bclk_fall,
        input  busy_n,
        input  common_request_n,
        input  priority_in,
        output busy_oe_dev,
        output common_request_line_oe_dev,
        output own_bus_request,
        output priority_out
    );

    modport far_end (
        input  busy_n,
        input  common_request_n,
        input  own_bus_request,
        input  priority_out,
        output bclk_fall,
        output busy_oe_far,
        output common_request_line_oe_far,
        output priority_in
    );

endinterface : arb_link_if

// >>> design/bus_clock_divider.sv
/*
 * Divides clk_sys down to the bus clock rate and marks each falling bus
 * clock edge with a one-cycle enable pulse.
 * Assumes a synchronous active-low reset on clk_sys.
 */
`timescale 1ns/1ps
module bus_clock_divider (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      bclk_fall
);

    logic [arb_pkg::DIV_W-1:0] count_q;
    logic [arb_pkg::DIV_W-1:0] count_d;
    logic                      fall_q;
    logic                      fall_d;

    // Count one bus clock period and flag its last system clock cycle.
    always_comb begin
        fall_d  = (count_q == arb_pkg::DIV_LAST);
        count_d = fall_d ? arb_pkg::DIV_RST : count_q + 1'b1;
    end

    // Register the divider state.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count_q <= arb_pkg::DIV_RST;
            fall_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            fall_q  <= fall_d;
        end
    end

    assign bclk_fall = fall_q;

endmodule : bus_clock_divider

// >>> design/arbiter_far_end.sv
/*
 * The rest of the shared bus as seen by one arbiter: a competing master with
 * its own arbiter, the priority resolver, and the bus clock source.
 * Assumes the device end is attached through arb_link_if.far_end.
 */
`timescale 1ns/1ps
module arbiter_far_end (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    arb_link_if.far_end link,
    input  wire logic   far_wants_bus,
    input  wire logic   far_cycle_done,
    input  wire logic   far_high_priority,
    input  wire logic   rotate_mode,
    input  wire logic   serial_mode,
    output logic        far_owns_bus
);

    arb_pkg::arb_state_type state_q;
    arb_pkg::arb_state_type state_d;
    logic                   busy_oe_q;
    logic                   busy_oe_d;
    logic                   common_request_line_oe_q;
    logic                   common_request_line_oe_d;
    logic                   turn_dev_q;
    logic                   turn_dev_d;
    logic                   dev_high;
    logic                   far_grant;
    logic                   far_owner;

    // The far end also produces the common bus clock.
    bus_clock_divider u_div (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .bclk_fall (link.bclk_fall)
    );

    assign far_owner = (state_q == arb_pkg::ARB_OWNER);

    // Resolve priority: fixed strap, or rotating turns for an equal share.
    always_comb begin
        dev_high = rotate_mode ? turn_dev_q : ~far_high_priority; // [R15]
        if (serial_mode) begin
            // Far arbiter heads the chain; its priority out feeds the device.
            link.priority_in = ~(far_wants_bus | far_owner); // [R14]
            far_grant        = 1'b1;
        end else begin
            // Only the highest active request sees its priority line.
            link.priority_in = link.own_bus_request & (~far_wants_bus | dev_high); // [R8]
            far_grant        = far_wants_bus & (~link.own_bus_request | ~dev_high); // [R8]
        end
    end

    // Competing arbiter: seize on a free bus, release only at a cycle boundary.
    always_comb begin
        state_d    = state_q;
        busy_oe_d  = busy_oe_q;
        common_request_line_oe_d  = common_request_line_oe_q;
        turn_dev_d = turn_dev_q;
        if (link.bclk_fall) begin
            unique case (state_q)
                arb_pkg::ARB_RELEASED, arb_pkg::ARB_WAITING: begin
                    common_request_line_oe_d = far_wants_bus & ~far_grant;
                    if (far_wants_bus && far_grant && link.busy_n) begin
                        state_d    = arb_pkg::ARB_OWNER;
                        busy_oe_d  = 1'b1; // [R11]
                        common_request_line_oe_d  = 1'b0;
                        turn_dev_d = 1'b1;
                    end else begin
                        state_d = far_wants_bus ? arb_pkg::ARB_WAITING : arb_pkg::ARB_RELEASED;
                    end
                end
                arb_pkg::ARB_OWNER: begin
                    // Keep the bus until the running cycle is over.
                    if (far_cycle_done && (!far_wants_bus || !far_grant)) begin // [R3]
                        state_d   = arb_pkg::ARB_RELEASED;
                        busy_oe_d = 1'b0; // [R11]
                    end
                end
            endcase
            if (!far_owner && !link.busy_n) begin
                turn_dev_d = 1'b0;
            end
        end
    end

    // Register the far arbiter state.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q    <= arb_pkg::ARB_RELEASED;
            busy_oe_q  <= 1'b0;
            common_request_line_oe_q  <= 1'b0;
            turn_dev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            busy_oe_q  <= busy_oe_d;
            common_request_line_oe_q  <= common_request_line_oe_d;
            turn_dev_q <= turn_dev_d;
        end
    end

    assign link.busy_oe_far = busy_oe_q;
    assign link.common_request_line_oe_far = common_request_line_oe_q;
    assign far_owns_bus     = busy_oe_q;

endmodule : arbiter_far_end

// >>> design/arbiter_device_end.sv
/*
 * Per-master arbiter that lets one processor and its bus controller onto a
 * shared multi-master system bus. It watches the processor status lines,
 * requests the bus, takes it when it holds priority and the bus is free,
 * and enables the controller, transceivers and latches only while it owns
 * the bus.
 * Assumes the link side is attached through arb_link_if.device_end, that the
 * status lines are synchronous to clk_sys, and that bus events are paced by
 * the bus clock fall pulse carried on the link.
 * Only the single shared bus scheme is provided: the processor wants the bus
 * for every status except idle and halt, and there is no bus lock input.
 * Assumes priority_in settles within one bus clock period, because it is
 * looked at only on the fall pulse; a longer priority chain breaks that.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// R1: Not owner keeps controller drivers off bus.
// R2: Owning re-enables controller so cycle proceeds.
// R3: Higher priority waits for owner's cycle end.
// R4: Lower priority gets bus when unused.
// R5: Any-request strap yields to lower requesters too.
// R6: Unrequested, keep bus until processor halts.
// R7: Release only on halt or other's request.
// R8: Parallel resolver grants highest request only.
// R9: New priority waits for current transaction end.
// R10: Completed and priority lost: release busy.
// R11: Busy is active-low wired-OR, drive low only.
// R12: Busy high with priority: take, drive low.
// R13: Arbitration events paced by bus clock.
// R14: Serial chain: priority out feeds next in.
// R15: Rotating resolver shares priority equally over time.
// R16: Daisy chain at most three arbiters.
// R17: Want bus, no priority: assert common request.
// R18: Seize busy on next bus clock fall.
// R19: Priority unneeded: pass it on via out.
// R20: Status 111 is idle, 011 is halt.
// R21: After reset bus released, controller disabled.
module arbiter_device_end (
    input  wire logic      clk_sys,
    input  wire logic      rst_n,
    arb_link_if.device_end link,
    input  wire logic [2:0] proc_status,
    input  wire logic      any_request_strap,
    output logic           controller_output_enable,
    output logic           bus_owned,
    output logic           waiting_for_bus
);

    ////////////////////////////////////////////////////////////////////////////
    // Status decoding.
    // Both codes also mark the end of a processor cycle, which is the only
    // point at which a surrender may take place.

    // True when the status lines show the idle code.
    function automatic logic status_is_idle(input logic [2:0] status);
        status_is_idle = (status == arb_pkg::STATUS_IDLE); // [R20]
    endfunction : status_is_idle

    // True when the status lines show the halt code.
    function automatic logic status_is_halt(input logic [2:0] status);
        status_is_halt = (status == arb_pkg::STATUS_HALT); // [R20]
    endfunction : status_is_halt

    arb_pkg::arb_state_type state_q;
    arb_pkg::arb_state_type state_d;
    logic                   busy_oe_q;
    logic                   busy_oe_d;
    logic                   common_request_line_oe_q;
    logic                   common_request_line_oe_d;
    logic                   request_q;
    logic                   request_d;
    logic                   enable_q;
    logic                   enable_d;
    logic                   proc_idle;
    logic                   proc_halt;
    logic                   proc_wants;
    logic                   at_boundary;
    logic                   lower_waiting;
    logic                   surrender;
    logic                   owner;

    // Classify the processor state each cycle.
    always_comb begin
        proc_idle   = status_is_idle(proc_status);
        proc_halt   = status_is_halt(proc_status);
        // Any active status other than idle or halt needs the shared bus.
        proc_wants  = ~proc_idle & ~proc_halt;
        // A cycle is over once the status lines go passive.
        at_boundary = proc_idle | proc_halt;
    end

    assign owner = (state_q == arb_pkg::ARB_OWNER);

    ////////////////////////////////////////////////////////////////////////////
    // Release decision.

    // The owner gives the bus up only at a cycle boundary, and only when it
    // halts or another master forces it off. A lower master waiting on the
    // common request counts only under the any-request strap.
    // Waiting for the boundary is what keeps a transfer whole: the status
    // lines only go passive once the processor has finished its cycle, so a
    // higher master never cuts into a transfer that is under way.
    always_comb begin
        // Our own common request is released while owning, so a low level
        // here comes from some other waiting arbiter.
        lower_waiting = ~link.common_request_n & ~common_request_line_oe_q;
        surrender     = 1'b0;
        if (at_boundary) begin // [R3] [R9]
            if (proc_halt) begin
                surrender = 1'b1; // [R6] [R7]
            end else if (!link.priority_in) begin
                surrender = 1'b1; // [R10]
            end else if (any_request_strap && lower_waiting) begin
                surrender = 1'b1; // [R5]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration state machine.

    // Every transition happens on a bus clock fall, which gives the outside
    // priority logic a full bus clock period to settle before it is sampled.
    // The request register lags the status lines by one pulse, so under the
    // parallel scheme priority can arrive at the earliest on the pulse after
    // the first request. The common request is pulled in the meantime, as a
    // higher master briefly does as well.
    always_comb begin
        state_d   = state_q;
        busy_oe_d = busy_oe_q;
        common_request_line_oe_d = common_request_line_oe_q;
        request_d = request_q;
        enable_d  = enable_q;
        if (link.bclk_fall) begin // [R13]
            unique case (state_q)
                arb_pkg::ARB_RELEASED, arb_pkg::ARB_WAITING: begin
                    request_d = proc_wants;
                    // Tell higher owners that someone below is waiting.
                    common_request_line_oe_d = proc_wants & ~link.priority_in; // [R17]
                    if (proc_wants && link.priority_in && link.busy_n) begin
                        // Priority held and bus free: seize it now.
                        state_d   = arb_pkg::ARB_OWNER; // [R4] [R12]
                        busy_oe_d = 1'b1; // [R11] [R18]
                        common_request_line_oe_d = 1'b0;
                        enable_d  = 1'b1; // [R2]
                    end else if (proc_wants) begin
                        // Still waiting for priority or for busy to rise.
                        state_d = arb_pkg::ARB_WAITING; // [R9]
                    end else begin
                        state_d = arb_pkg::ARB_RELEASED;
                    end
                end
                arb_pkg::ARB_OWNER: begin
                    if (surrender) begin
                        // Let busy float high and pull the drivers off.
                        state_d   = arb_pkg::ARB_RELEASED;
                        busy_oe_d = 1'b0; // [R10] [R11]
                        request_d = 1'b0;
                        enable_d  = 1'b0; // [R1]
                    end else begin
                        // Nobody forced us off: hold the bus.
                        request_d = 1'b1; // [R6] [R7]
                    end
                end
            endcase
        end
    end

    // Register the arbitration state; reset leaves the bus released.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q   <= arb_pkg::ARB_RELEASED; // [R21]
            busy_oe_q <= 1'b0;
            common_request_line_oe_q <= 1'b0;
            request_q <= 1'b0;
            enable_q  <= 1'b0; // [R1]
        end else begin
            state_q   <= state_d;
            busy_oe_q <= busy_oe_d;
            common_request_line_oe_q <= common_request_line_oe_d;
            request_q <= request_d;
            enable_q  <= enable_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link and local outputs.

    // Open-drain lines are only ever pulled low or let go.
    assign link.busy_oe_dev     = busy_oe_q;
    assign link.common_request_line_oe_dev     = common_request_line_oe_q;
    assign link.own_bus_request = request_q;

    // Priority is passed straight down when this master has no use for it,
    // so a chain below sees it without waiting for a bus clock.
    assign link.priority_out = link.priority_in & ~proc_wants & ~owner; // [R19]

    // Busy and the controller enable are set and cleared on the same edge, so
    // the controller never drives a bus before this arbiter holds busy low,
    // and it is pulled off in the same cycle as busy is let go.
    // The waiting flag is a plain state decode for local monitoring.
    // The controller, transceivers and latches drive only while we own.
    assign controller_output_enable = enable_q; // [R1] [R2]
    assign bus_owned                = busy_oe_q;
    assign waiting_for_bus          = (state_q == arb_pkg::ARB_WAITING);

endmodule : arbiter_device_end

// >>> test/multimaster_bus_arbiter_asserts.sv
/*
 * Checker for the link that joins the device end and the far end.
 * Assumes it sees the link signals plus clk_sys and rst_n of the bench.
 */
`timescale 1ns/1ps
module multimaster_bus_arbiter_asserts (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       bclk_fall,
    input wire logic       busy_oe_dev,
    input wire logic       busy_oe_far,
    input wire logic       common_request_line_oe_dev,
    input wire logic       busy_n,
    input wire logic       own_bus_request,
    input wire logic       priority_in,
    input wire logic       priority_out,
    input wire logic [2:0] proc_status
);
    // Every check runs on the system clock and pauses while reset is low.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // Busy is never pulled by both ends, so only one master owns the bus.
    a_single_owner: assert property (!(busy_oe_dev && busy_oe_far))
        else $error("both ends pull busy low");
    // Busy only moves just after a bus clock fall.
    a_paced_busy: assert property ($changed(busy_oe_dev) |-> $past(bclk_fall) || $past(bclk_fall, 2))
        else $error("busy changed away from a bus clock fall");
    // A seize needs priority and a free bus at the deciding pulse.
    a_seize_needs_grant: assert property ($rose(busy_oe_dev) |->
        ($past(priority_in) || $past(priority_in, 2)) && ($past(busy_n) || $past(busy_n, 2)))
        else $error("busy seized without priority or while busy");
    // The common request is only raised by a waiting non-owner.
    a_common_request_line_waiting: assert property (common_request_line_oe_dev |-> own_bus_request && !busy_oe_dev)
        else $error("common request without a pending request");
    // Priority is passed on only when the processor is idle or halted and this end does not own.
    a_prio_pass: assert property (priority_out == (priority_in && !busy_oe_dev &&
        (proc_status == arb_pkg::STATUS_IDLE || proc_status == arb_pkg::STATUS_HALT)))
        else $error("priority out wrong");
    // A seized bus is held until the next decision pulse at least.
    a_busy_stands: assert property ($rose(busy_oe_dev) |-> busy_oe_dev [*3])
        else $error("busy dropped too early");
    // A release also drops the bus request.
    a_release_clean: assert property ($fell(busy_oe_dev) |-> !own_bus_request)
        else $error("request kept after release");
    // Decision pulses come every fourth cycle.
    a_pulse_spacing: assert property (bclk_fall |=> !bclk_fall [*3] ##1 bclk_fall)
        else $error("bus clock fall spacing wrong");
    // Coming out of reset nothing is pulled or requested.
    a_reset_idle: assert property ($rose(rst_n) |-> !busy_oe_dev && !common_request_line_oe_dev && !own_bus_request)
        else $error("link lines active after reset");
endmodule : multimaster_bus_arbiter_asserts

// >>> test/multimaster_bus_arbiter_tb_top.sv
/*
 * Self-checking bench for the arbiter pair joined by the link, with random
 * processor and competitor traffic compared against a bench model.
 * Assumes the design files and the link checker are compiled first.
 */
`timescale 1ns/1ps
module multimaster_bus_arbiter_tb_top;
    logic        clk_sys;
    logic        rst_n;
    logic [2:0]  proc_status;
    logic        any_request_strap;
    logic        far_wants_bus;
    logic        far_cycle_done;
    logic        far_high_priority;
    logic        rotate_mode;
    logic        serial_mode;
    logic        controller_output_enable;
    logic        bus_owned;
    logic        waiting_for_bus;
    logic        far_owns_bus;
    logic [31:0] rng;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          dev_wins;
    int          far_wins;
    bit          own_m;
    bit          wait_m;
    bit          want;
    // Arbiters in the serial chain of this bench: far end first, then device end.
    localparam int CHAIN_LEN = 2;

    arb_link_if link ();

    arbiter_device_end i_arbiter_device_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .proc_status(proc_status), .any_request_strap(any_request_strap),
        .controller_output_enable(controller_output_enable), .bus_owned(bus_owned),
        .waiting_for_bus(waiting_for_bus));

    arbiter_far_end i_arbiter_far_end (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .far_wants_bus(far_wants_bus), .far_cycle_done(far_cycle_done),
        .far_high_priority(far_high_priority), .rotate_mode(rotate_mode),
        .serial_mode(serial_mode), .far_owns_bus(far_owns_bus));

    multimaster_bus_arbiter_asserts i_multimaster_bus_arbiter_asserts (.clk_sys(clk_sys),
        .proc_status(proc_status), .rst_n(rst_n), .bclk_fall(link.bclk_fall), .busy_oe_dev(link.busy_oe_dev),
        .busy_oe_far(link.busy_oe_far), .common_request_line_oe_dev(link.common_request_line_oe_dev), .busy_n(link.busy_n),
        .own_bus_request(link.own_bus_request), .priority_in(link.priority_in),
        .priority_out(link.priority_out));

    ////////////////////////////////////////////////////////////////////////////
    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic conclude();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Steps the xorshift generator once.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    ////////////////////////////////////////////////////////////////////////////
    // The 40 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Cuts a hang short well beyond the planned run length.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors++;
            conclude();
        end
    end

    // Checks the grant each cycle except in rotate mode; at each decision pulse compares and steps the model.
    always @(negedge clk_sys) begin
        if (!rst_n) begin
            own_m = 1'b0;
            wait_m = 1'b0;
        end else begin
            if (serial_mode) begin
                check({2'h0, link.priority_in}, {2'h0, !(far_wants_bus || far_owns_bus)}, "chain");
            end else if (!rotate_mode) begin
                check({2'h0, link.priority_in},
                    {2'h0, link.own_bus_request && (!far_wants_bus || !far_high_priority)}, "grant");
            end
            if (link.bclk_fall === 1'b1) begin
                check({controller_output_enable, bus_owned, waiting_for_bus},
                    {own_m, own_m, wait_m}, "device");
                dev_wins += (bus_owned === 1'b1);
                far_wins += (far_owns_bus === 1'b1);
                want = proc_status != arb_pkg::STATUS_IDLE && proc_status != arb_pkg::STATUS_HALT;
                if (own_m) begin
                    own_m = want || !(proc_status == arb_pkg::STATUS_HALT || !link.priority_in
                        || (any_request_strap && !link.common_request_n));
                    wait_m = 1'b0;
                end else begin
                    own_m = want && link.priority_in && link.busy_n;
                    wait_m = want && !own_m;
                end
            end
        end
    end

    // Runs every mode with and without the strap, with a reset between modes.
    initial begin
        rng = 32'h37;
        rst_n = 1'b0;
        proc_status = arb_pkg::STATUS_IDLE;
        any_request_strap = 1'b0;
        far_wants_bus = 1'b0;
        far_cycle_done = 1'b0;
        far_high_priority = 1'b0;
        rotate_mode = 1'b0;
        serial_mode = 1'b0;
        repeat (10) @(posedge clk_sys);
        for (int cfg = 0; cfg < 8; cfg++) begin
            rst_n <= 1'b0;
            any_request_strap <= cfg[0];
            far_high_priority <= cfg[1];
            rotate_mode <= (cfg[2:1] == 2'h2);
            serial_mode <= (cfg[2:1] == 2'h3);
            repeat (2) @(posedge clk_sys);
            rst_n <= 1'b1;
            dev_wins = 0;
            far_wins = 0;
            for (int n = 0; n < 600; n++) begin
                @(posedge clk_sys);
                rng = xs(rng);
                if (rng[3:0] == 4'h0) proc_status <= rng[6:4];
                if (rng[11:8] == 4'h0) far_wants_bus <= rng[12];
                far_cycle_done <= rng[13] | rng[14];
            end
            if (rotate_mode) check({2'h0, dev_wins > 0 && far_wins > 0}, 3'h1, "share");
            if (serial_mode) check({2'h0, CHAIN_LEN <= arb_pkg::MAX_CHAIN_LEN}, 3'h1, "chain length");
        end
        conclude();
    end
endmodule : multimaster_bus_arbiter_tb_top
